// *** verilog/sms_pkg.sv ***
// Package for the switch mode and fault supervisor.
// Shared constants: APB map, field positions, resets, timing counts.
package sms_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned WDOG_TIMEOUT_MS = 310;
  localparam int unsigned IN_IDLE_MS = 250;
  localparam int unsigned WDOG_CYC = WDOG_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned IN_IDLE_CYC = IN_IDLE_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 24;

  // APB byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PWM0 = 8'h04;
  localparam logic [7:0] ADDR_PWM1 = 8'h08;
  localparam logic [7:0] ADDR_GSTAT = 8'h0C;
  localparam logic [7:0] ADDR_CFLT0 = 8'h10;
  localparam logic [7:0] ADDR_CFLT1 = 8'h14;
  localparam logic [7:0] ADDR_MODE = 8'h18;
  localparam logic [7:0] ADDR_SPIWORD = 8'h1C;

  // Control register fields
  localparam int CTRL_WDOFF = 0;
  localparam int CTRL_LSLEN = 1;
  localparam int CTRL_STHEN = 2;
  localparam int CTRL_PAR = 3;
  localparam int CTRL_DIRDIS0 = 4;
  localparam int CTRL_DIRDIS1 = 5;
  localparam int CTRL_POR = 6;
  localparam int CTRL_W = 7;
  localparam logic [6:0] CTRL_RST = 7'h44;
  // Pulse-width register: on bit position
  localparam int PWM_ON = 8;
  localparam logic [8:0] PWM_RST = 9'h000;
  // Global status: undervoltage, supply too high, clock fail
  localparam int GS_UV = 0;
  localparam int GS_STH = 1;
  localparam int GS_CLK = 2;
  // Channel fault: overcurrent, short, overtemp
  localparam int CF_OC = 0;
  localparam int CF_SC = 1;
  localparam int CF_OT = 2;
  // Word from host serial engine: watchdog toggle bit
  localparam int WD_BIT = 15;

  typedef enum logic [2:0] {
    SMS_SLEEP, SMS_NORMAL, SMS_FAILSAFE, SMS_FAULT, SMS_FS_FAULT
  } sms_mode_t;
endpackage : sms_pkg

// *** verilog/sms_chan_guard.sv ***
// One channel's input-activity timer, fault control and latch keeper.
// Assumes inputs already synchronised to pclk.
`timescale 1ns/1ps
module sms_chan_guard
  import sms_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Controls
  input wire logic in_level,
  input wire logic dir_dis,
  input wire logic on_bit,
  input wire logic ch_fault,
  input wire logic retry_expired,
  input wire logic delatch_all,
  // Status
  output logic in_activity,
  output logic fault_control,
  output logic latched
);
  logic [CNT_W-1:0] idle_q;
  logic fc_d;
  logic fc_q;
  logic fc_zero_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_q <= '0;
      in_activity <= 1'b0;
    end else if (in_level) begin
      idle_q <= '0;
      in_activity <= 1'b1;
    end else if (idle_q >= CNT_W'(IN_IDLE_CYC)) begin
      in_activity <= 1'b0;
    end else begin
      idle_q <= idle_q + 1'b1;
    end
  end

  assign fc_d = (in_activity & ~dir_dis) | on_bit;
  assign fault_control = fc_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fc_q <= 1'b0;
      fc_zero_q <= 1'b0;
    end else begin
      fc_q <= fc_d;
      if (!latched) begin
        fc_zero_q <= 1'b0;
      end else if (fc_q && !fc_d) begin
        fc_zero_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched <= 1'b0;
    end else if (delatch_all) begin
      latched <= 1'b0;
    end else if (latched && fc_zero_q && !fc_q && fc_d && !ch_fault) begin
      latched <= 1'b0;
    end else if (ch_fault && retry_expired) begin
      latched <= 1'b1;
    end
  end
endmodule : sms_chan_guard

// *** verilog/sms_supervisor.sv ***
// Mode and fault supervisor of a dual high-side switch, APB slave.
// Assumes pins and host words arrive asynchronously; pclk is 40 MHz.
`timescale 1ns/1ps
module sms_supervisor
  import sms_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins from outside
  input wire logic reset_pin_n,
  input wire logic [1:0] in_pin,
  input wire logic logic_supply_ok,
  input wire logic word_toggle,
  input wire logic [15:0] word_data,
  // Fault sensors
  input wire logic [1:0] overcurrent,
  input wire logic [1:0] short_circuit,
  input wire logic [1:0] overtemperature,
  input wire logic undervoltage,
  input wire logic supply_too_high,
  input wire logic clock_fail,
  input wire logic [1:0] retry_expired,
  // Outputs
  output logic failsafe_out_n,
  output logic fault_flag_n,
  output logic [1:0] channel_on,
  output logic serial_on
);
  // Synchronisers, registers and internal signals
  logic [1:0] rst_s1_q, rst_s2_q;
  logic [1:0] in_s1_q, in_s2_q;
  logic [1:0] ls_s1_q, ls_s2_q;
  logic tg_s1_q, tg_s2_q, tg_s3_q;
  logic rst_prev_q;
  logic [15:0] word_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [8:0] pwm_q [2];
  logic [2:0] gstat_q;
  logic [2:0] cflt_q [2];
  logic wd_prev_q;
  logic wd_run_q;
  logic [CNT_W-1:0] wd_cnt_q;
  logic exit_wait_q;
  logic [CNT_W-1:0] exit_cnt_q;
  logic lsup_seen_q;
  sms_mode_t mode_q;
  logic [1:0] in_act;
  logic [1:0] latched;
  logic [1:0] latched_prev_q;
  logic wake, wd_timeout, failsafe_term, fault_term, word_evt, rst_rise;
  logic reg_reset, delatch_all, acc, wr, rd, regs_open;
  logic [1:0] ch_fault;
  logic [31:0] rdata_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_s1_q <= '0;
      rst_s2_q <= '0;
      in_s1_q <= '0;
      in_s2_q <= '0;
      ls_s1_q <= '0;
      ls_s2_q <= '0;
      tg_s1_q <= 1'b0;
      tg_s2_q <= 1'b0;
      tg_s3_q <= 1'b0;
      rst_prev_q <= 1'b0;
      word_q <= '0;
    end else begin
      rst_s1_q <= {1'b0, reset_pin_n};
      rst_s2_q <= rst_s1_q;
      in_s1_q <= in_pin;
      in_s2_q <= in_s1_q;
      ls_s1_q <= {1'b0, logic_supply_ok};
      ls_s2_q <= ls_s1_q;
      tg_s1_q <= word_toggle;
      tg_s2_q <= tg_s1_q;
      tg_s3_q <= tg_s2_q;
      rst_prev_q <= rst_s2_q[0];
      if (tg_s2_q != tg_s3_q) begin
        word_q <= word_data;
      end
    end
  end

  assign word_evt = tg_s2_q != tg_s3_q;
  assign rst_rise = rst_s2_q[0] & ~rst_prev_q;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      assign ch_fault[gi] = overcurrent[gi] | short_circuit[gi] | overtemperature[gi];
      sms_chan_guard u_guard (
        .pclk(pclk),
        .presetn(presetn),
        .in_level(in_s2_q[gi]),
        .dir_dis(ctrl_q[CTRL_DIRDIS0 + gi]),
        .on_bit(pwm_q[gi][PWM_ON]),
        .ch_fault(ch_fault[gi]),
        .retry_expired(retry_expired[gi]),
        .delatch_all(delatch_all),
        .in_activity(in_act[gi]),
        .fault_control(),
        .latched(latched[gi])
      );
    end
  endgenerate

  assign wake = rst_s2_q[0] | in_act[0] | in_act[1];
  assign fault_term = (|ch_fault) | undervoltage | (supply_too_high & ctrl_q[CTRL_STHEN])
    | clock_fail;
  assign failsafe_term = (lsup_seen_q & ~ls_s2_q[0] & ctrl_q[CTRL_LSLEN]) | wd_timeout;
  assign wd_timeout = wd_run_q & ~ctrl_q[CTRL_WDOFF] & (wd_cnt_q >= CNT_W'(WDOG_CYC));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_run_q <= 1'b0;
      wd_cnt_q <= '0;
      wd_prev_q <= 1'b0;
      lsup_seen_q <= 1'b0;
    end else begin
      if (ls_s2_q[0]) begin
        lsup_seen_q <= 1'b1;
      end
      if (rst_rise && ls_s2_q[0]) begin
        wd_run_q <= 1'b1;
        wd_cnt_q <= '0;
      end else if (!rst_s2_q[0]) begin
        wd_run_q <= 1'b0;
        wd_cnt_q <= '0;
      end else if (word_evt) begin
        wd_prev_q <= word_data[WD_BIT];
        if (word_data[WD_BIT] != wd_prev_q) begin
          wd_cnt_q <= '0;
        end
      end else if (wd_run_q && wd_cnt_q < CNT_W'(WDOG_CYC)) begin
        wd_cnt_q <= wd_cnt_q + 1'b1;
      end
    end
  end

  // Exit from fail-safe: D15 word then second word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exit_wait_q <= 1'b0;
      exit_cnt_q <= '0;
    end else if (mode_q != SMS_FAILSAFE) begin
      exit_wait_q <= 1'b0;
      exit_cnt_q <= '0;
    end else if (word_evt && !exit_wait_q && word_data[WD_BIT]) begin
      exit_wait_q <= 1'b1;
      exit_cnt_q <= '0;
    end else if (exit_wait_q && exit_cnt_q >= CNT_W'(WDOG_CYC)) begin
      exit_wait_q <= 1'b0;
    end else if (exit_wait_q) begin
      exit_cnt_q <= exit_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= SMS_SLEEP;
    end else begin
      case (mode_q)
        SMS_SLEEP: if (wake) mode_q <= fault_term ? SMS_FAULT : SMS_NORMAL;
        SMS_NORMAL: begin
          if (!wake) mode_q <= SMS_SLEEP;
          else if (fault_term) mode_q <= SMS_FAULT;
          else if (failsafe_term) mode_q <= SMS_FAILSAFE;
        end
        SMS_FAULT: begin
          if (!wake) mode_q <= SMS_SLEEP;
          else if (failsafe_term) mode_q <= SMS_FS_FAULT;
          else if (!fault_term) mode_q <= SMS_NORMAL;
        end
        SMS_FAILSAFE: begin
          if (!wake) mode_q <= SMS_SLEEP;
          else if (fault_term) mode_q <= SMS_FS_FAULT;
          else if (exit_wait_q && word_evt) mode_q <= SMS_NORMAL;
        end
        SMS_FS_FAULT: begin
          if (!wake) mode_q <= SMS_SLEEP;
          else if (!fault_term) mode_q <= SMS_FAILSAFE;
        end
        default: mode_q <= SMS_SLEEP;
      endcase
    end
  end

  // Fail-safe entry delatches and resets registers
  assign delatch_all = failsafe_term & wake &
    ((mode_q == SMS_NORMAL) | (mode_q == SMS_FAULT));
  // Return to normal resets registers too
  assign reg_reset = delatch_all | (mode_q == SMS_SLEEP) |
    ((mode_q == SMS_FAILSAFE) & exit_wait_q & word_evt);
  // Register access refused in fail-safe and sleep, except at the mode register
  assign regs_open = (mode_q == SMS_NORMAL) | (mode_q == SMS_FAULT);
  assign acc = psel & penable;
  assign wr = acc & pwrite & regs_open;
  assign rd = acc & ~pwrite & regs_open;

  // Control and pulse-width registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      pwm_q[0] <= PWM_RST;
      pwm_q[1] <= PWM_RST;
    end else if (reg_reset) begin
      ctrl_q <= (CTRL_RST & ~(7'(1) << CTRL_PAR) & ~(7'(1) << CTRL_POR))
        | (ctrl_q & ((7'(1) << CTRL_PAR) | (7'(1) << CTRL_POR)));
      pwm_q[0] <= PWM_RST;
      pwm_q[1] <= PWM_RST;
    end else if (wr) begin
      if (paddr == ADDR_CTRL) ctrl_q <= pwdata[CTRL_W-1:0];
      if (paddr == ADDR_PWM0) pwm_q[0] <= pwdata[8:0];
      if (paddr == ADDR_PWM1) pwm_q[1] <= pwdata[8:0];
    end
  end

  // Sticky fault bits, set wins over read clear but not over register reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gstat_q <= '0;
      cflt_q[0] <= '0;
      cflt_q[1] <= '0;
      latched_prev_q <= '0;
    end else begin
      latched_prev_q <= latched;
      if (reg_reset) begin
        gstat_q <= '0;
      end else if (rd && paddr == ADDR_GSTAT) begin
        gstat_q <= {clock_fail, supply_too_high, undervoltage};
      end else begin
        gstat_q <= gstat_q | {clock_fail, supply_too_high & ctrl_q[CTRL_STHEN], undervoltage};
      end
      for (int i = 0; i < 2; i++) begin
        if (reg_reset && !latched[i]) begin
          cflt_q[i] <= '0;
        end else if (!latched[i] && (latched_prev_q[i] ||
            (rd && paddr == (i == 0 ? ADDR_CFLT0 : ADDR_CFLT1)))) begin
          cflt_q[i] <= {overtemperature[i], short_circuit[i], overcurrent[i]};
        end else begin
          cflt_q[i] <= cflt_q[i] | {overtemperature[i], short_circuit[i], overcurrent[i]};
        end
      end
    end
  end

  always_comb begin
    rdata_d = '0;
    case (paddr)
      ADDR_CTRL: rdata_d[CTRL_W-1:0] = ctrl_q;
      ADDR_PWM0: rdata_d[8:0] = pwm_q[0];
      ADDR_PWM1: rdata_d[8:0] = pwm_q[1];
      ADDR_GSTAT: rdata_d[2:0] = gstat_q;
      ADDR_CFLT0: rdata_d[2:0] = cflt_q[0];
      ADDR_CFLT1: rdata_d[2:0] = cflt_q[1];
      ADDR_MODE: rdata_d[6:0] = {latched, in_act, mode_q};
      ADDR_SPIWORD: rdata_d[15:0] = word_q;
      default: rdata_d = '0;
    endcase
  end

  // APB answer: no wait state, error on unmapped or closed access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      prdata <= rdata_d;
      pslverr <= (paddr > ADDR_SPIWORD) | (paddr[1:0] != 2'b00) |
        (!regs_open && paddr != ADDR_MODE);
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_on <= '0;
      failsafe_out_n <= 1'b1;
      fault_flag_n <= 1'b1;
      serial_on <= 1'b0;
    end else begin
      serial_on <= mode_q != SMS_SLEEP;
      failsafe_out_n <= !(mode_q == SMS_FAILSAFE || mode_q == SMS_FS_FAULT);
      fault_flag_n <= !(fault_term | (|latched));
      for (int i = 0; i < 2; i++) begin
        if (mode_q == SMS_SLEEP || undervoltage ||
            (supply_too_high && ctrl_q[CTRL_STHEN]) || ch_fault[i] || latched[i]) begin
          channel_on[i] <= 1'b0;
        end else if (mode_q == SMS_FAILSAFE || mode_q == SMS_FS_FAULT) begin
          channel_on[i] <= in_s2_q[i];
        end else begin
          channel_on[i] <= (in_s2_q[i] & ~ctrl_q[CTRL_DIRDIS0 + i]) | pwm_q[i][PWM_ON];
        end
      end
    end
  end
endmodule : sms_supervisor

// *** tb/sms_supervisor_sva.sv ***
// Checker on the supervisor's top ports.
// Assumes one pclk domain with presetn as its reset.
`timescale 1ns/1ps
module sms_supervisor_sva
  import sms_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and sensors
  input wire logic reset_pin_n,
  input wire logic [1:0] overcurrent,
  input wire logic undervoltage,
  input wire logic failsafe_out_n,
  input wire logic fault_flag_n,
  input wire logic [1:0] channel_on,
  input wire logic serial_on
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_asleep;
    (!serial_on && failsafe_out_n) [*2];
  endsequence
  sequence s_oc0;
    overcurrent[0] [*3];
  endsequence
  sequence s_uv;
    undervoltage [*3];
  endsequence
  sleep_off_a: assert property (
    s_asleep |-> channel_on == 2'h0) else $error("channels on while asleep");
  wake_serial_a: assert property (
    (reset_pin_n && failsafe_out_n) [*8] |-> serial_on) else $error("no wake on reset pin");
  oc_off_a: assert property (
    s_oc0 |-> !channel_on[0]) else $error("channel on during overcurrent");
  fault_pin_a: assert property (
    s_oc0 |-> !fault_flag_n) else $error("fault flag high during fault");
  uv_both_a: assert property (
    s_uv |-> channel_on == 2'h0) else $error("channel on in undervoltage");
  ready_next_a: assert property (
    s_setup |=> pready) else $error("no ready after setup");
  ready_pulse_a: assert property (
    pready |=> !pready) else $error("ready longer than a cycle");
  err_ready_a: assert property (
    pslverr |-> pready) else $error("error without ready");
  unmapped_err_a: assert property (
    pready && (paddr > 8'h1C || paddr[1:0] != 2'h0) |-> pslverr) else $error("bad address ok");
endmodule : sms_supervisor_sva

bind sms_supervisor sms_supervisor_sva sms_supervisor_sva_inst (.pclk, .presetn, .psel,
  .penable, .paddr, .pready, .pslverr, .reset_pin_n, .overcurrent, .undervoltage,
  .failsafe_out_n, .fault_flag_n, .channel_on, .serial_on);

// *** tb/sms_host_model.sv ***
// Host model: hands 16-bit words to the supervisor.
// Assumes the bench calls send_word; link_clk runs at 200 ns.
`timescale 1ns/1ps
module sms_host_model
  import sms_pkg::*;
(
  // Link side
  input wire logic link_clk,
  output logic word_toggle,
  output logic [15:0] word_data
);
  initial begin
    word_toggle = 1'h0;
    word_data = 16'h0000;
  end
  task automatic send_word(input logic [15:0] w);
    @(posedge link_clk);
    word_data <= w;
    @(posedge link_clk);
    word_toggle <= ~word_toggle;
    repeat (2) @(posedge link_clk);
    // Stale data shows inverted
    word_data <= ~w;
  endtask : send_word
endmodule : sms_host_model

// *** tb/tb_top.sv ***
// Bench for the supervisor: APB tasks, host model, pins and faults.
// Assumes 40 MHz pclk and fault sensors on the same clock.
`timescale 1ns/1ps
module tb_top;
  import sms_pkg::*;
  typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] x; logic e;} sms_row_t;
  logic pclk, presetn, psel, penable, pwrite, link_clk, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, reset_pin_n, logic_supply_ok, undervoltage;
  logic [1:0] in_pin, overcurrent, retry_expired, channel_on;
  logic word_toggle, failsafe_out_n, fault_flag_n, serial_on;
  logic supply_too_high, clock_fail;
  logic [15:0] word_data;
  int err_count, n_tests;
  sms_row_t rows [8] = '{
    '{ADDR_CTRL, 1'h0, 32'h0, 32'(CTRL_RST), 1'h0},
    '{ADDR_MODE, 1'h0, 32'h0, 32'(SMS_NORMAL), 1'h0},
    '{ADDR_GSTAT, 1'h0, 32'h0, 32'h0, 1'h0},
    '{ADDR_PWM1, 1'h1, 32'h100, 32'h0, 1'h0},
    '{ADDR_PWM1, 1'h0, 32'h0, 32'h100, 1'h0},
    '{ADDR_PWM1, 1'h1, 32'h0, 32'h0, 1'h0},
    '{8'h20, 1'h0, 32'h0, 32'h0, 1'h1},
    '{8'h02, 1'h0, 32'h0, 32'h0, 1'h1}
  };

  sms_supervisor sms_supervisor_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .reset_pin_n, .in_pin, .logic_supply_ok,
    .word_toggle, .word_data, .overcurrent, .short_circuit(2'h0), .overtemperature(2'h0),
    .undervoltage, .supply_too_high, .clock_fail, .retry_expired,
    .failsafe_out_n, .fault_flag_n, .channel_on, .serial_on);
  sms_host_model sms_host_model_inst (.link_clk, .word_toggle, .word_data);

  task automatic test_done();
    if (err_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'h1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
    apb(a, 1'h0, 32'h0);
    check(rd, x);
    check(32'(err), 32'h0);
  endtask : rdchk
  task automatic pins(input logic [4:0] x);
    check(32'({failsafe_out_n, fault_flag_n, channel_on, serial_on}), 32'(x));
  endtask : pins

  initial begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    link_clk = 1'h0;
    forever #100 link_clk = ~link_clk;
  end
  initial begin
    #500000;
    err_count++;
    test_done();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, reset_pin_n} = '0;
    {in_pin, undervoltage, overcurrent, retry_expired, supply_too_high, clock_fail} = '0;
    logic_supply_ok = 1'h1;
    err_count = 0;
    n_tests = 0;
    repeat (16) @(posedge pclk);
    pins(5'h18);
    presetn <= 1'h1;
    @(posedge pclk);
    rdchk(ADDR_MODE, 32'(SMS_SLEEP));
    apb(ADDR_CTRL, 1'h1, 32'h1);
    check(32'(err), 32'h1);
    reset_pin_n <= 1'h1;
    while (serial_on !== 1'h1) @(posedge pclk);
    pins(5'h19);
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      if (!rows[i].w) check(rd, rows[i].x);
      check(32'(err), 32'(rows[i].e));
    end
    apb(ADDR_PWM0, 1'h1, 32'h100);
    repeat (4) @(posedge pclk);
    pins(5'h1B);
    sms_host_model_inst.send_word(16'hA5C3);
    repeat (4) @(posedge pclk);
    rdchk(ADDR_SPIWORD, 32'hA5C3);
    overcurrent <= 2'h1;
    repeat (4) @(posedge pclk);
    pins(5'h11);
    rdchk(ADDR_MODE, 32'(SMS_FAULT));
    overcurrent <= 2'h0;
    repeat (4) @(posedge pclk);
    check(32'(fault_flag_n), 32'h1);
    rdchk(ADDR_CFLT0, 32'h1);
    rdchk(ADDR_CFLT0, 32'h0);
    overcurrent <= 2'h1;
    retry_expired <= 2'h1;
    repeat (4) @(posedge pclk);
    overcurrent <= 2'h0;
    retry_expired <= 2'h0;
    repeat (4) @(posedge pclk);
    pins(5'h11);
    rdchk(ADDR_CFLT0, 32'h1);
    rdchk(ADDR_CFLT0, 32'h1);
    apb(ADDR_PWM0, 1'h1, 32'h0);
    apb(ADDR_PWM0, 1'h1, 32'h100);
    repeat (4) @(posedge pclk);
    pins(5'h1B);
    rdchk(ADDR_CFLT0, 32'h0);
    undervoltage <= 1'h1;
    repeat (4) @(posedge pclk);
    pins(5'h11);
    undervoltage <= 1'h0;
    repeat (4) @(posedge pclk);
    rdchk(ADDR_GSTAT, 32'h1 << GS_UV);
    supply_too_high <= 1'h1;
    repeat (4) @(posedge pclk);
    pins(5'h11);
    supply_too_high <= 1'h0;
    repeat (4) @(posedge pclk);
    rdchk(ADDR_GSTAT, 32'h1 << GS_STH);
    apb(ADDR_CTRL, 1'h1, 32'h46);
    logic_supply_ok <= 1'h0;
    in_pin <= 2'h2;
    repeat (8) @(posedge pclk);
    pins(5'h0D);
    apb(ADDR_CTRL, 1'h0, 32'h0);
    check(32'(err), 32'h1);
    rdchk(ADDR_MODE, 32'h12);
    clock_fail <= 1'h1;
    repeat (4) @(posedge pclk);
    pins(5'h05);
    rdchk(ADDR_MODE, 32'h14);
    clock_fail <= 1'h0;
    repeat (4) @(posedge pclk);
    pins(5'h0D);
    logic_supply_ok <= 1'h1;
    sms_host_model_inst.send_word(16'h8000);
    sms_host_model_inst.send_word(16'h0001);
    repeat (8) @(posedge pclk);
    check(32'(failsafe_out_n), 32'h1);
    rdchk(ADDR_CTRL, 32'(CTRL_RST));
    overcurrent <= 2'h2;
    retry_expired <= 2'h2;
    repeat (4) @(posedge pclk);
    overcurrent <= 2'h0;
    retry_expired <= 2'h0;
    repeat (4) @(posedge pclk);
    rdchk(ADDR_MODE, 32'h51);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    pins(5'h18);
    presetn <= 1'h1;
    while (serial_on !== 1'h1) @(posedge pclk);
    rdchk(ADDR_MODE, 32'h11);
    test_done();
  end
endmodule : tb_top
